/* File: hdl/mtfc_tunnel_end.sv */
// Purpose: Tunnel sublayer end: wraps native units into tunnel frames, unwraps received ones
// Assumes: Client holds dest/src/subtype stable from first payload octet until it is taken
// Notes:   Pad is not stripped on receive; clients use their own length fields

// ****************************************
// Payload buffer
// ****************************************
module mtfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Pointer compare with wrap bit
  assign empty       = (wr_q == rd_q);
  assign full        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  assign push        = ce_i && in_valid_i && !full;
  assign pop         = ce_i && out_ready_i && !empty;

  // Storage
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ****************************************
// Tunnel end
// ****************************************
// Behaviour
// - Tunnel Ethertype marks and identifies tunnel frames
// - Send header, subtype, payload, pad, then FCS
// - Multi-octet values go most significant octet first
// - Bits in an octet go LSB first
// - Pad only when payload under 45 octets
// - Pad octets zero; pad ignored on receive (here pad is passed to the client as payload)
// - Destination is consumer's unicast MAC address
// - Source is generator's individual MAC address
// - MAC computes and appends the FCS
// - Subtype 0x00 is tunnel configuration
// - Subtypes 0x01, 0x02 reserved, ignored on receive
// - Subtype 0x03 carries maintenance unit
// - Subtype 0x04 carries ONU management message
// - Subtype 0x05 carries whole Ethernet frame
// - Subtype 0x06 carries layer-3 packet with Ethertype
// - Subtypes 0x07 to 0xFD reserved, ignored
// - Subtypes 0xFE, 0xFF organization-specific, identifier follows
// - Only config subtype goes to config client
// - Received payload unwrapped, delivered to its client
// - Transmitted payload starts as native unit, wrapped here
module mtfc_tunnel_end (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  mtfc_link_if.tunnel      link,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  input  wire logic        tx_last_i,
  output logic             tx_ready_o,
  input  wire logic [47:0] tx_dest_i,
  input  wire logic [47:0] tx_src_i,
  input  wire logic [7:0]  tx_subtype_i,
  output logic [7:0]       rx_data_o,
  output logic             rx_last_o,
  output logic             rx_cfg_valid_o,
  output logic             rx_proto_valid_o,
  output logic             rx_pass_valid_o,
  output logic [7:0]       rx_subtype_o,
  output logic [47:0]      rx_dest_o,
  output logic [47:0]      rx_src_o,
  output logic [15:0]      rx_len_type_o
);
  mtfc_pkg::mtfc_tx_state_t st_q;
  mtfc_pkg::mtfc_tx_state_t st_d;
  logic [3:0]  idx_q;
  logic [5:0]  pay_q;
  logic [47:0] dest_q;
  logic [47:0] src_q;
  logic [7:0]  sub_q;
  logic [8:0]  f_data;
  logic        f_valid;
  logic        f_ready;
  logic        fire;
  logic        pay_full;
  logic        start;

  // Native unit octets buffered ahead of the framer
  mtfc_fifo #(
    .WIDTH (mtfc_pkg::FIFO_WIDTH),
    .DEPTH (mtfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_data_i   ({tx_last_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready)
  );

  // ****************************************
  // Transmit framer
  // ****************************************

  // Octet select and link handshake
  assign pay_full      = (pay_q >= mtfc_pkg::MIN_PAYLOAD - 6'h1);
  assign start         = (st_q == mtfc_pkg::TX_IDLE) && f_valid;
  assign link.tx_data  = (st_q == mtfc_pkg::TX_HDR) ? mtfc_pkg::hdr_byte(idx_q, dest_q, src_q) :
                         (st_q == mtfc_pkg::TX_SUB) ? sub_q :
                         (st_q == mtfc_pkg::TX_PAY) ? f_data[7:0] :
                         mtfc_pkg::PAD_OCTET;
  assign link.tx_valid = (st_q == mtfc_pkg::TX_HDR) || (st_q == mtfc_pkg::TX_SUB) ||
                         (st_q == mtfc_pkg::TX_PAD) || ((st_q == mtfc_pkg::TX_PAY) && f_valid);
  assign link.tx_last  = ((st_q == mtfc_pkg::TX_PAD) && pay_full) ||
                         ((st_q == mtfc_pkg::TX_PAY) && f_data[8] && pay_full);
  assign f_ready       = (st_q == mtfc_pkg::TX_PAY) && link.tx_ready;
  assign fire          = ce_i && link.tx_valid && link.tx_ready;

  // Field order: header, subtype, payload, pad; FCS left to the MAC
  always_comb begin
    st_d = st_q;
    case (st_q)
      mtfc_pkg::TX_IDLE: if (start) st_d = mtfc_pkg::TX_HDR;
      mtfc_pkg::TX_HDR:  if (fire && idx_q == mtfc_pkg::HDR_LAST_IDX) st_d = mtfc_pkg::TX_SUB;
      mtfc_pkg::TX_SUB:  if (fire) st_d = mtfc_pkg::TX_PAY;
      mtfc_pkg::TX_PAY: begin
        if (fire && f_data[8]) begin
          st_d = pay_full ? mtfc_pkg::TX_IDLE : mtfc_pkg::TX_PAD;
        end
      end
      mtfc_pkg::TX_PAD:  if (fire && pay_full) st_d = mtfc_pkg::TX_IDLE;
      default:           st_d = mtfc_pkg::TX_IDLE;
    endcase
  end

  // State, counters and latched header fields
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q   <= mtfc_pkg::TX_IDLE;
      idx_q  <= '0;
      pay_q  <= '0;
      dest_q <= '0;
      src_q  <= '0;
      sub_q  <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      if (start) begin
        idx_q  <= '0;
        pay_q  <= '0;
        dest_q <= tx_dest_i;
        src_q  <= tx_src_i;
        sub_q  <= tx_subtype_i;
      end
      if (fire && st_q == mtfc_pkg::TX_HDR) idx_q <= idx_q + 4'h1;
      if (fire && (st_q == mtfc_pkg::TX_PAY || st_q == mtfc_pkg::TX_PAD) && pay_q != mtfc_pkg::PAY_SAT) begin
        pay_q <= pay_q + 6'h1;
      end
    end
  end

  // ****************************************
  // Receive parser
  // ****************************************
  mtfc_pkg::mtfc_kind_t kind_q;
  logic [3:0]           rc_q;
  logic                 rx_take;
  logic                 lt_match;
  logic                 cfg_hit;
  logic                 proto_hit;
  logic                 pass_hit;

  // Octet class decode from position and frame kind
  assign rx_take   = ce_i && link.rx_valid;
  assign lt_match  = ({rx_len_type_o[15:8], link.rx_data} == mtfc_pkg::TUNNEL_ETHERTYPE);
  assign cfg_hit   = rx_take && (rc_q == mtfc_pkg::PAYLOAD_IDX) &&
                     (kind_q == mtfc_pkg::RK_CFG);
  assign proto_hit = rx_take && (rc_q == mtfc_pkg::PAYLOAD_IDX) &&
                     (kind_q == mtfc_pkg::RK_PROTO);
  assign pass_hit  = rx_take && (rc_q >= mtfc_pkg::SUBTYPE_IDX) &&
                     (kind_q == mtfc_pkg::RK_PASS);

  // Header capture, frame class and delivery pulses; pad goes out as payload
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_q             <= '0;
      kind_q           <= mtfc_pkg::RK_HDR;
      rx_data_o        <= '0;
      rx_last_o        <= 1'b0;
      rx_cfg_valid_o   <= 1'b0;
      rx_proto_valid_o <= 1'b0;
      rx_pass_valid_o  <= 1'b0;
      rx_subtype_o     <= '0;
      rx_dest_o        <= '0;
      rx_src_o         <= '0;
      rx_len_type_o    <= '0;
    end else if (ce_i) begin
      rx_cfg_valid_o   <= cfg_hit;
      rx_proto_valid_o <= proto_hit;
      rx_pass_valid_o  <= pass_hit;
      rx_last_o        <= link.rx_last && (cfg_hit || proto_hit || pass_hit);
      if (rx_take) begin
        rx_data_o <= link.rx_data;
        if (rc_q != mtfc_pkg::PAYLOAD_IDX) rc_q <= rc_q + 4'h1;
        if (rc_q < mtfc_pkg::DEST_END_IDX) rx_dest_o <= {rx_dest_o[39:0], link.rx_data};
        else if (rc_q < mtfc_pkg::SRC_END_IDX) rx_src_o <= {rx_src_o[39:0], link.rx_data};
        if (rc_q == mtfc_pkg::SRC_END_IDX) rx_len_type_o[15:8] <= link.rx_data;
        if (rc_q == mtfc_pkg::LEN_TYPE_LO_IDX) begin
          rx_len_type_o[7:0] <= link.rx_data;
          kind_q             <= lt_match ? mtfc_pkg::RK_HDR : mtfc_pkg::RK_PASS;
        end
        // Subtype classes
        if (rc_q == mtfc_pkg::SUBTYPE_IDX && kind_q == mtfc_pkg::RK_HDR) begin
          rx_subtype_o <= link.rx_data;
          kind_q       <= mtfc_pkg::classify(link.rx_data);
        end
        if (link.rx_last) begin
          rc_q   <= '0;
          kind_q <= mtfc_pkg::RK_HDR;
        end
      end
    end
  end
endmodule

/* File: shared/mtfc_pkg.sv */
// Purpose: Shared constants, types and helpers for the management tunnel frame codec
// Assumes: Octet-wide link between tunnel end and MAC end, one clock
// Notes:   Subtype classes drive receive routing; header bytes built by function
package mtfc_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [15:0] TUNNEL_ETHERTYPE = 16'hA8C8;
  localparam logic [3:0]  HDR_LAST_IDX     = 4'hD;   // Index of last header octet
  localparam logic [3:0]  LEN_TYPE_LO_IDX  = 4'hD;   // Low octet of len/type on receive
  localparam logic [3:0]  SUBTYPE_IDX      = 4'hE;   // Subtype octet follows len/type
  localparam logic [3:0]  PAYLOAD_IDX      = 4'hF;   // First payload octet (saturates)
  localparam logic [3:0]  DEST_END_IDX     = 4'h6;
  localparam logic [3:0]  SRC_END_IDX      = 4'hC;
  localparam logic [5:0]  MIN_PAYLOAD      = 6'h2D;  // 45 octets incl. pad
  localparam logic [5:0]  PAY_SAT          = 6'h3F;
  localparam logic [7:0]  PAD_OCTET        = 8'h00;

  // ****************************************
  // Subtype encoding
  // ****************************************
  localparam logic [7:0] SUB_CONFIG  = 8'h00;
  localparam logic [7:0] SUB_DISC_LO = 8'h01;
  localparam logic [7:0] SUB_DISC_HI = 8'h02;
  localparam logic [7:0] SUB_MAINT   = 8'h03;
  localparam logic [7:0] SUB_ONU     = 8'h04;
  localparam logic [7:0] SUB_L2      = 8'h05;
  localparam logic [7:0] SUB_L3      = 8'h06;
  localparam logic [7:0] SUB_RSV_HI  = 8'hFD;
  localparam logic [7:0] SUB_ORG_LO  = 8'hFE;

  // ****************************************
  // Buffering and check sequence
  // ****************************************
  localparam int          FIFO_WIDTH = 9;
  localparam int          FIFO_DEPTH = 16;
  localparam logic [31:0] CRC_POLY   = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
  localparam logic [2:0]  BIT_TOP    = 3'h7;
  localparam logic [5:0]  FCS_TOP    = 6'h1F;

  // Transmit framer states, Gray from TX_IDLE to TX_PAD; TX_PAD to TX_IDLE flips two bits
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_HDR  = 3'b001,
    TX_SUB  = 3'b011,
    TX_PAY  = 3'b010,
    TX_PAD  = 3'b110
  } mtfc_tx_state_t;

  // Receive frame classes
  typedef enum logic [2:0] {
    RK_HDR   = 3'b000,
    RK_PASS  = 3'b001,
    RK_CFG   = 3'b011,
    RK_PROTO = 3'b010,
    RK_DROP  = 3'b110
  } mtfc_kind_t;

  // Serial line states at the MAC end
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_DATA = 2'b01,
    LN_FCS  = 2'b11
  } mtfc_line_state_t;

  // Header octet idx: addresses and len/type, most significant octet first
  function automatic logic [7:0] hdr_byte(input logic [3:0] idx, input logic [47:0] da,
                                          input logic [47:0] sa);
    logic [111:0] s;
    s = {da, sa, TUNNEL_ETHERTYPE} >> {HDR_LAST_IDX - idx, 3'b000};
    return s[7:0];
  endfunction

  // Class of a received subtype
  function automatic mtfc_kind_t classify(input logic [7:0] sub);
    if (sub == SUB_CONFIG)
      return RK_CFG;
    else if (sub >= SUB_MAINT && sub <= SUB_L3)
      return RK_PROTO;
    else if (sub >= SUB_ORG_LO)
      return RK_PROTO;
    else
      return RK_DROP;
  endfunction

  // One LSB-first step of the reflected check sequence
  function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
    return (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
  endfunction

endpackage

/* File: shared/mtfc_link_if.sv */
// Purpose: Octet link between the tunnel end and the MAC control end
// Assumes: Single clock; tx uses valid/ready, rx has no back-pressure
// Notes:   last marks the final octet of a frame
interface mtfc_link_if;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic       tx_last;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_last;

  modport tunnel (output tx_data, output tx_valid, output tx_last, input tx_ready,
                  input rx_data, input rx_valid, input rx_last);
  modport mac (input tx_data, input tx_valid, input tx_last, output tx_ready,
               output rx_data, output rx_valid, output rx_last);
endinterface

/* File: hdl/mtfc_mac_end.sv */
// Purpose: MAC control end: serialises tunnel frames and feeds received octets
// Assumes: Received octets arrive already framed and without FCS
// Notes:   One octet per nine clocks on the serial line
module mtfc_mac_end (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  mtfc_link_if.mac        link,
  output logic            line_tx_bit_o,
  output logic            line_tx_en_o,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  input  wire logic       rx_last_i
);
  mtfc_pkg::mtfc_line_state_t st_q;
  logic [31:0] sh_q;
  logic [5:0]  bc_q;
  logic        last_q;
  logic [31:0] crc_q;
  logic        take;

  // Accept an octet only between octets
  assign link.tx_ready = (st_q == mtfc_pkg::LN_IDLE);
  assign take          = ce_i && link.tx_valid && (st_q == mtfc_pkg::LN_IDLE);

  // ****************************************
  // Serial transmit with check sequence
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q          <= mtfc_pkg::LN_IDLE;
      sh_q          <= '0;
      bc_q          <= '0;
      last_q        <= 1'b0;
      crc_q         <= mtfc_pkg::CRC_INIT;
      line_tx_bit_o <= 1'b0;
      line_tx_en_o  <= 1'b0;
    end else if (ce_i) begin
      case (st_q)
        mtfc_pkg::LN_IDLE: begin
          line_tx_en_o <= 1'b0;
          if (take) begin
            st_q          <= mtfc_pkg::LN_DATA;
            line_tx_bit_o <= link.tx_data[0];
            line_tx_en_o  <= 1'b1;
            sh_q          <= {25'h0, link.tx_data[7:1]};
            bc_q          <= {3'h0, mtfc_pkg::BIT_TOP};
            last_q        <= link.tx_last;
            crc_q         <= mtfc_pkg::crc_bit(crc_q, link.tx_data[0]);
          end
        end
        mtfc_pkg::LN_DATA: begin
          if (bc_q != 6'h0) begin
            line_tx_bit_o <= sh_q[0];
            sh_q          <= sh_q >> 1;
            bc_q          <= bc_q - 6'h1;
            crc_q         <= mtfc_pkg::crc_bit(crc_q, sh_q[0]);
          end else if (last_q) begin
            st_q          <= mtfc_pkg::LN_FCS;
            line_tx_bit_o <= ~crc_q[0];
            sh_q          <= ~crc_q >> 1;
            bc_q          <= mtfc_pkg::FCS_TOP;
          end else begin
            st_q         <= mtfc_pkg::LN_IDLE;
            line_tx_en_o <= 1'b0;
          end
        end
        mtfc_pkg::LN_FCS: begin
          if (bc_q != 6'h0) begin
            line_tx_bit_o <= sh_q[0];
            sh_q          <= sh_q >> 1;
            bc_q          <= bc_q - 6'h1;
          end else begin
            st_q         <= mtfc_pkg::LN_IDLE;
            line_tx_en_o <= 1'b0;
            crc_q        <= mtfc_pkg::CRC_INIT;
          end
        end
        default: st_q <= mtfc_pkg::LN_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receive octets toward the tunnel end
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link.rx_data  <= '0;
      link.rx_valid <= 1'b0;
      link.rx_last  <= 1'b0;
    end else if (ce_i) begin
      link.rx_data  <= rx_data_i;
      link.rx_valid <= rx_valid_i;
      link.rx_last  <= rx_valid_i && rx_last_i;
    end
  end
endmodule

/* File: sim/mtfc_link_asserts.sv */
// Purpose: Link checks between tunnel end and MAC end
// Assumes: One clock, reset async active low
// Notes:   Octet position counted from link takes
module mtfc_link_asserts (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       tx_last,
  input wire logic       rx_valid,
  input wire logic       rx_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take;
  logic [7:0] idx_q;
  logic [7:0] idx_d;

  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ****************************************
  // Octet position in frame
  // ****************************************
  assign take  = tx_valid && tx_ready;
  assign idx_d = tx_last ? 8'h00 : idx_q + 8'h01;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) idx_q <= 8'h00;
    else if (take) idx_q <= idx_d;
  end

  // ****************************************
  // Properties
  // ****************************************
  sequence s_busy;
    !tx_ready [*8];
  endsequence
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  property p_octet_gap;
    take |=> s_busy;
  endproperty
  property p_fcs_gap;
    take && tx_last |=> s_busy ##1 s_busy ##1 s_busy ##1 s_busy ##1 s_busy;
  endproperty
  property p_type_hi;
    take && idx_q == 8'h0C |-> tx_data == 8'hA8;
  endproperty
  property p_type_lo;
    take && idx_q == 8'h0D |-> tx_data == 8'hC8;
  endproperty
  property p_min_len;
    take && tx_last |-> idx_q >= 8'h3B;
  endproperty
  property p_ready_back;
    take |-> ##[1:60] tx_ready;
  endproperty
  property p_last_valid;
    (tx_last |-> tx_valid) and (rx_last |-> rx_valid);
  endproperty
  property p_reset_idle;
    $rose(rst_b_i) |-> !tx_valid && !rx_valid;
  endproperty

  a_hold:       assert property (p_hold) else $error("link octet changed while waiting");
  a_octet_gap:  assert property (p_octet_gap) else $error("link taken during serial octet");
  a_fcs_gap:    assert property (p_fcs_gap) else $error("no room left for check sequence");
  a_type_hi:    assert property (p_type_hi) else $error("len type high octet wrong");
  a_type_lo:    assert property (p_type_lo) else $error("len type low octet wrong");
  a_min_len:    assert property (p_min_len) else $error("frame shorter than minimum");
  a_ready_back: assert property (p_ready_back) else $error("link ready never returned");
  a_last_valid: assert property (p_last_valid) else $error("last without valid");
  a_reset_idle: assert property (p_reset_idle) else $error("link active out of reset");
endmodule

/* File: sim/mgmt_tunnel_frame_codec_tb_top.sv */
// Purpose: Bench for tunnel end and MAC end joined by the link
// Assumes: Clock enable held high
// Notes:   Serial octets gathered LSB first
module mgmt_tunnel_frame_codec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
  localparam logic [47:0] DA = 48'h0200_0000_0A01;
  localparam logic [47:0] SA = 48'h0200_0000_0B02;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  tx_d = 8'h00, tx_sub = 8'h00, rx_d = 8'h00, sh, last_d;
  logic        tx_v = 1'b0, tx_l = 1'b0, rx_v = 1'b0, rx_l = 1'b0, tx_rdy, ln_bit, ln_en;
  logic        r_cfg, r_pro, r_pas, r_last, saw_full;
  logic [7:0]  r_d, r_sub;
  logic [47:0] r_da, r_sa;
  logic [15:0] r_lt;
  logic [7:0]  line_q[$];
  int          n_mismatch = 0, n_compared = 0, nb = 0, n_cfg, n_pro, n_pas, n_lst;

  // ****************************************
  // Design and checker
  // ****************************************
  mtfc_link_if link ();
  mtfc_tunnel_end u_mtfc_tunnel_end (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .link(link),
    .tx_data_i(tx_d), .tx_valid_i(tx_v), .tx_last_i(tx_l), .tx_ready_o(tx_rdy), .tx_dest_i(DA),
    .tx_src_i(SA), .tx_subtype_i(tx_sub), .rx_data_o(r_d), .rx_last_o(r_last), .rx_cfg_valid_o(r_cfg),
    .rx_proto_valid_o(r_pro), .rx_pass_valid_o(r_pas), .rx_subtype_o(r_sub), .rx_dest_o(r_da),
    .rx_src_o(r_sa), .rx_len_type_o(r_lt));
  mtfc_mac_end u_mtfc_mac_end (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .link(link),
    .line_tx_bit_o(ln_bit), .line_tx_en_o(ln_en), .rx_data_i(rx_d), .rx_valid_i(rx_v), .rx_last_i(rx_l));
  mtfc_link_asserts u_mtfc_link_asserts (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tx_data(link.tx_data),
    .tx_valid(link.tx_valid), .tx_ready(link.tx_ready), .tx_last(link.tx_last), .rx_valid(link.rx_valid),
    .rx_last(link.rx_last));

  // Clock
  always #12.5 mclk_i = ~mclk_i;

  // Serial octet capture and receive pulse counts
  always @(posedge mclk_i) begin
    if (ln_en === 1'b1) begin
      sh = {ln_bit, sh[7:1]};
      nb++;
      if (nb == 8) begin
        line_q.push_back(sh);
        nb = 0;
      end
    end
    if (r_cfg === 1'b1) n_cfg++;
    if (r_pro === 1'b1) n_pro++;
    if (r_pas === 1'b1) n_pas++;
    if (r_last === 1'b1) n_lst++;
    if (r_cfg === 1'b1 || r_pro === 1'b1 || r_pas === 1'b1) last_d = r_d;
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Native unit into tunnel end, octet i is i+0x11
  task automatic send(input logic [7:0] sub, input int n);
    int w;
    tx_sub = sub;
    for (int i = 0; i < n; i++) begin
      #1 tx_d = 8'h11 + i[7:0];
      tx_v = 1'b1;
      tx_l = (i == n - 1);
      @(negedge mclk_i);
      w = 0;
      while (tx_rdy !== 1'b1 && w < 300) begin
        saw_full = 1'b1;
        @(negedge mclk_i);
        w++;
      end
      @(posedge mclk_i);
    end
    #1 tx_v = 1'b0;
    tx_l = 1'b0;
  endtask

  // Whole serial frame against header, pad and check sequence
  task automatic check_tx(input logic [7:0] sub, input int n);
    logic [7:0]  e[$];
    logic [31:0] c;
    int          w;
    for (int i = 5; i >= 0; i--) e.push_back(DA[8*i+:8]);
    for (int i = 5; i >= 0; i--) e.push_back(SA[8*i+:8]);
    e.push_back(8'hA8);
    e.push_back(8'hC8);
    e.push_back(sub);
    for (int i = 0; i < 45 || i < n; i++) e.push_back(i < n ? 8'h11 + i[7:0] : 8'h00);
    c = 32'hFFFF_FFFF;
    foreach (e[k]) for (int b = 0; b < 8; b++) c = (c[0] ^ e[k][b]) ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    for (int i = 0; i < 4; i++) e.push_back(~c[8*i+:8]);
    w = 0;
    while (line_q.size() < e.size() && w < 3000) begin
      @(posedge mclk_i);
      w++;
    end
    repeat (20) @(posedge mclk_i);
    `CHK("line octets", e.size(), line_q.size())
    foreach (e[i]) `CHK("line octet", e[i], line_q[i])
    line_q.delete();
  endtask

  // Received frame into MAC end, three payload octets
  task automatic rx_frame(input logic [15:0] lt, input logic [7:0] sub);
    logic [7:0] f[$];
    for (int i = 5; i >= 0; i--) f.push_back(DA[8*i+:8]);
    for (int i = 5; i >= 0; i--) f.push_back(SA[8*i+:8]);
    f = {f, lt[15:8], lt[7:0], sub, 8'h5A, 8'h6B, 8'h7C};
    n_cfg = 0;
    n_pro = 0;
    n_pas = 0;
    n_lst = 0;
    foreach (f[i]) begin
      #1 rx_d = f[i];
      rx_v = 1'b1;
      rx_l = (i == f.size() - 1);
      @(posedge mclk_i);
    end
    #1 rx_v = 1'b0;
    rx_l = 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] subs[] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'hFD, 8'hFE, 8'hFF};
    logic       cfg;
    logic       pro;
    repeat (3) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    @(posedge mclk_i);
    // Short units padded, subtypes 0x00, 0x03 to 0x06 and 0xFE
    foreach (subs[i]) if (subs[i] inside {8'h00, [8'h03:8'h06], 8'hFE}) begin
      send(subs[i], 3);
      check_tx(subs[i], 3);
    end
    // Long unit fills the buffer, no pad
    saw_full = 1'b0;
    send(8'h05, 50);
    `CHK("buffer full seen", 1'b1, saw_full)
    check_tx(8'h05, 50);
    // Receive routing per subtype
    foreach (subs[i]) begin
      cfg = (subs[i] == 8'h00);
      pro = subs[i] inside {[8'h03:8'h06], 8'hFE, 8'hFF};
      rx_frame(16'hA8C8, subs[i]);
      `CHK("cfg pulses", cfg ? 3 : 0, n_cfg)
      `CHK("proto pulses", pro ? 3 : 0, n_pro)
      `CHK("pass pulses", 0, n_pas)
      `CHK("rx subtype", subs[i], r_sub)
      if (cfg || pro) `CHK("rx last octet", 8'h7C, last_d)
      `CHK("rx last pulses", (cfg || pro) ? 1 : 0, n_lst)
    end
    `CHK("rx dest", DA, r_da)
    `CHK("rx src", SA, r_sa)
    rx_frame(16'h0800, 8'h03);
    `CHK("pass pulses", 4, n_pas)
    `CHK("pass proto", 0, n_pro)
    `CHK("pass last pulses", 1, n_lst)
    `CHK("rx len type", 16'h0800, r_lt)
    test_done();
  end

  // Watchdog
  initial begin
    #200us;
    n_mismatch++;
    test_done();
  end
endmodule
